// ==== hw/icc_pkg.sv ====
// icc_pkg: constants, types and register map of the input capture channel
// assumes an apb slave with 12-bit byte addresses and 32-bit data
package icc_pkg;

  // register indices; the byte address is four times the index
  localparam logic [9:0]  ICC_IDX_BUF  = 10'h140;
  localparam logic [9:0]  ICC_IDX_CON  = 10'h142;
  localparam logic [9:0]  ICC_IDX_STAT = 10'h144;
  localparam logic [9:0]  ICC_IDX_MASK = 10'h146;
  localparam logic [11:0] ICC_ADDR_BUF  = {ICC_IDX_BUF, 2'b00};
  localparam logic [11:0] ICC_ADDR_CON  = {ICC_IDX_CON, 2'b00};
  localparam logic [11:0] ICC_ADDR_STAT = {ICC_IDX_STAT, 2'b00};
  localparam logic [11:0] ICC_ADDR_MASK = {ICC_IDX_MASK, 2'b00};

  // control register field positions
  localparam int ICC_CON_SIDL = 13;
  localparam int ICC_CON_TSEL = 7;
  localparam int ICC_CON_EVC  = 5;
  localparam int ICC_CON_OV   = 4;
  localparam int ICC_CON_BNE  = 3;
  localparam int ICC_CON_MODE = 0;
  localparam logic [15:0] ICC_CON_RESET = 16'h0000;

  // status / mask layout
  localparam int ICC_ST_CAP = 0;
  localparam int ICC_ST_OVF = 1;
  localparam logic [1:0] ICC_ST_RESET = 2'h0;

  // fifo shape and prescale terminal counts
  localparam int ICC_DEPTH = 4;
  localparam int ICC_WIDTH = 16;
  localparam logic [3:0] ICC_PRE4_LAST  = 4'h3;
  localparam logic [3:0] ICC_PRE16_LAST = 4'hf;

  typedef enum logic [2:0] {
    ICC_OFF   = 3'b000,
    ICC_BOTH  = 3'b001,
    ICC_FALL  = 3'b010,
    ICC_RISE  = 3'b011,
    ICC_PRE4  = 3'b100,
    ICC_PRE16 = 3'b101,
    ICC_RSVD  = 3'b110,
    ICC_INT   = 3'b111
  } icc_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } icc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } icc_apb_rsp_t;

endpackage

// ==== hw/icc_edge_sync.sv ====
// icc_edge_sync: two-flop synchroniser and edge detector for the pin
// assumes the pin is asynchronous to i_clock
`timescale 1ns/1ps
module icc_edge_sync (
  input  wire logic i_clock,
  input  wire logic i_rst_b,
  input  wire logic i_pin,
  output logic      o_rise,
  output logic      o_fall
);
  logic meta;
  logic sync;
  logic prev;

  // first flop feeds only the second one
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  // one pulse per edge
  assign o_rise = sync & ~prev;
  assign o_fall = ~sync & prev;
endmodule

// ==== hw/icc_fifo.sv ====
// icc_fifo: shift fifo, head always in entry 0
// assumes caller never pushes when full nor pops when empty
`timescale 1ns/1ps
module icc_fifo (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  input  wire logic        i_push,
  input  wire logic [15:0] i_data,
  input  wire logic        i_pop,
  output logic [15:0]      o_head,
  output logic [2:0]       o_count,
  output logic             o_full,
  output logic             o_empty
);
  logic [15:0] entry [icc_pkg::ICC_DEPTH];
  logic [2:0]  count;
  logic [2:0]  wr_pos;

  // a pop moves the write slot down with the data
  assign wr_pos = i_pop ? count - 3'h1 : count;

  // per entry: shift forward on pop, load at the free slot on push
  for (genvar g = 0; g < icc_pkg::ICC_DEPTH; g++) begin : g_ent
    // last entry points at itself so no index runs past the array
    localparam int NXT = (g < icc_pkg::ICC_DEPTH - 1) ? g + 1 : g;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
        entry[g] <= 16'h0000;
      end else if (i_push && wr_pos == 3'(g)) begin
        entry[g] <= i_data;
      end else if (i_pop && g < icc_pkg::ICC_DEPTH - 1) begin
        entry[g] <= entry[NXT];
      end
    end
  end

  // occupancy
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= 3'h0;
    end else begin
      count <= count + 3'(i_push) - 3'(i_pop);
    end
  end

  assign o_head  = entry[0];
  assign o_count = count;
  assign o_full  = count == 3'(icc_pkg::ICC_DEPTH);
  assign o_empty = count == 3'h0;
endmodule

// ==== hw/icc_capture_channel.sv ====
// icc_capture_channel: one input capture channel with apb registers
// assumes the two timer counts and run bits come from outside, the cpu
// power state arrives as sleep and idle levels, and the pin is async
`timescale 1ns/1ps

// Overview of operation
// - capture falling, rising, every 4th, every 16th rising, or both edges.
// - edge prescaler cleared when channel is off and on reset.
// - captures held in a four entry, 16-bit fifo.
// - not-empty flag set by first capture, held until fifo drained.
// - each read returns oldest entry and shifts the rest forward.
// - capture into full fifo sets overflow and is discarded.
// - after overflow nothing is captured until all four are read.
// - reading an empty fifo gives an undefined value; software checks.
// - control bit 7 picks the timer; second timer is the reset default.
// - both-edges mode flags every edge, ignores count, never overflows.
// - mode 111 with enable set wakes from sleep or idle, timer or not.
// - in sleep only mode 111 rising edges act, as an interrupt source.
// - in idle full function only with timer running and stop bit low.
// - mode 111 in idle makes the pin a pure interrupt input.
// - interrupt raised after the event count set in bits 6 to 5.
// - one interrupt flag per channel, requested only when enabled; here capture and overflow each have a status flag.
module icc_capture_channel (
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_b,
  input  wire icc_pkg::icc_apb_req_t i_apb,
  output icc_pkg::icc_apb_rsp_t     o_apb,
  input  wire logic                 i_capture_input_pin,
  input  wire logic [15:0]          i_timer2_count,
  input  wire logic [15:0]          i_timer3_count,
  input  wire logic                 i_timer2_on,
  input  wire logic                 i_timer3_on,
  input  wire logic                 i_sleep,
  input  wire logic                 i_idle,
  output logic                      o_irq,
  output logic                      o_wake
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic        setup_ph;
  logic        acc_ph;
  logic        wr_con;
  logic        wr_mask;
  logic        rd_buf;
  logic        rd_stat;
  logic        hit;
  logic [31:0] prdata;
  logic        pslverr;

  assign setup_ph = i_apb.psel & ~i_apb.penable;
  assign acc_ph   = i_apb.psel & i_apb.penable;
  assign hit      = i_apb.paddr == icc_pkg::ICC_ADDR_BUF  ||
                    i_apb.paddr == icc_pkg::ICC_ADDR_CON  ||
                    i_apb.paddr == icc_pkg::ICC_ADDR_STAT ||
                    i_apb.paddr == icc_pkg::ICC_ADDR_MASK;
  assign wr_con  = acc_ph & i_apb.pwrite &
                   i_apb.paddr == icc_pkg::ICC_ADDR_CON;
  assign wr_mask = acc_ph & i_apb.pwrite &
                   i_apb.paddr == icc_pkg::ICC_ADDR_MASK;
  assign rd_buf  = acc_ph & ~i_apb.pwrite &
                   i_apb.paddr == icc_pkg::ICC_ADDR_BUF;
  assign rd_stat = acc_ph & ~i_apb.pwrite &
                   i_apb.paddr == icc_pkg::ICC_ADDR_STAT;

  ////////////////////////////////////////////////////////////////////////
  // control register fields

  logic                stop_in_idle;
  logic                timebase_select;
  logic [1:0]          interrupt_event_count;
  icc_pkg::icc_mode_t  capture_mode_field;
  logic [1:0]          status;
  logic [1:0]          mask;

  // writable control bits; flags are read-only
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stop_in_idle          <= icc_pkg::ICC_CON_RESET[icc_pkg::ICC_CON_SIDL];
      timebase_select       <= icc_pkg::ICC_CON_RESET[icc_pkg::ICC_CON_TSEL];
      interrupt_event_count <=
        icc_pkg::ICC_CON_RESET[icc_pkg::ICC_CON_EVC +: 2];
      capture_mode_field    <= icc_pkg::ICC_OFF;
    end else if (wr_con) begin
      stop_in_idle          <= i_apb.pwdata[icc_pkg::ICC_CON_SIDL];
      timebase_select       <= i_apb.pwdata[icc_pkg::ICC_CON_TSEL];
      interrupt_event_count <= i_apb.pwdata[icc_pkg::ICC_CON_EVC +: 2];
      capture_mode_field    <= icc_pkg::icc_mode_t'(
                                 i_apb.pwdata[icc_pkg::ICC_CON_MODE +: 3]);
    end
  end

  // interrupt enables, same layout as status
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask <= icc_pkg::ICC_ST_RESET;
    end else if (wr_mask) begin
      mask <= i_apb.pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin edges and mode qualification

  logic       rise;
  logic       fall;
  logic [3:0] presc;
  logic       presc_hit;
  logic       edge_sel;
  logic       mode_off;
  logic       is_hall;
  logic       is_int;
  logic       timer_on;
  logic       full_fn;
  logic       int_only;
  logic       evt;

  icc_edge_sync u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_pin   (i_capture_input_pin),
    .o_rise  (rise),
    .o_fall  (fall)
  );

  assign mode_off = capture_mode_field == icc_pkg::ICC_OFF;
  assign is_hall  = capture_mode_field == icc_pkg::ICC_BOTH;
  assign is_int   = capture_mode_field == icc_pkg::ICC_INT;
  assign timer_on = timebase_select ? i_timer2_on : i_timer3_on;
  // idle keeps function only with the timer running and stop bit low
  assign full_fn  = ~i_sleep & (~i_idle | (timer_on & ~stop_in_idle));
  // in sleep or idle, mode 111 only makes interrupts
  assign int_only = (i_sleep | i_idle) & is_int & rise;

  assign presc_hit =
    (capture_mode_field == icc_pkg::ICC_PRE4  &&
     presc == icc_pkg::ICC_PRE4_LAST) ||
    (capture_mode_field == icc_pkg::ICC_PRE16 &&
     presc == icc_pkg::ICC_PRE16_LAST);

  // edge chosen by the mode field
  always_comb begin
    unique case (capture_mode_field)
      icc_pkg::ICC_BOTH:  edge_sel = rise | fall;
      icc_pkg::ICC_FALL:  edge_sel = fall;
      icc_pkg::ICC_RISE:  edge_sel = rise;
      icc_pkg::ICC_PRE4,
      icc_pkg::ICC_PRE16: edge_sel = rise & presc_hit;
      icc_pkg::ICC_INT:   edge_sel = rise;
      icc_pkg::ICC_OFF,
      icc_pkg::ICC_RSVD:  edge_sel = 1'b0;
    endcase
  end

  // capture event proper; mode 111 while asleep or idle stores nothing
  assign evt = edge_sel & full_fn & ~(i_idle & is_int);

  // edge prescaler; stalls in sleep since 4:1 and 16:1 do not apply
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc <= 4'h0;
    end else if (mode_off) begin
      presc <= 4'h0;
    end else if (rise && full_fn &&
                 (capture_mode_field == icc_pkg::ICC_PRE4 ||
                  capture_mode_field == icc_pkg::ICC_PRE16)) begin
      presc <= presc_hit ? 4'h0 : presc + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture fifo and overflow

  logic        push;
  logic        pop;
  logic [15:0] head;
  logic [2:0]  count;
  logic        full;
  logic        empty;
  logic        locked;
  logic        ovf_evt;
  logic [15:0] stamp;
  logic        head_ok;

  assign stamp   = timebase_select ? i_timer2_count : i_timer3_count;
  assign ovf_evt = evt & full & ~locked & ~is_hall;
  assign push    = evt & ~full & ~locked;
  // pop only a word that was shown at setup; a push landing between
  // setup and access of an empty read must not be thrown away
  // an empty read pops nothing and shows a stale word
  assign pop     = rd_buf & head_ok;

  icc_fifo u_fifo (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_push  (push),
    .i_data  (stamp),
    .i_pop   (pop),
    .o_head  (head),
    .o_count (count),
    .o_full  (full),
    .o_empty (empty)
  );

  // overflow holds off captures until the fifo has been drained
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      locked <= 1'b0;
    end else if (ovf_evt) begin
      locked <= 1'b1;
    end else if (empty) begin
      locked <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt counting, status, wake

  logic [1:0] ev_cnt;
  logic       cap_irq;

  // every edge in both-edges mode, else every n-th capture event
  assign cap_irq = int_only |
                   (evt & (is_hall | ev_cnt == interrupt_event_count));

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ev_cnt <= 2'h0;
    end else if (mode_off) begin
      ev_cnt <= 2'h0;
    end else if (evt && !is_hall) begin
      ev_cnt <= ev_cnt == interrupt_event_count ? 2'h0 : ev_cnt + 2'h1;
    end
  end

  // sticky status; a read clears only the bits it returned at setup,
  // so an event between setup and access is not lost; new events win
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      status <= icc_pkg::ICC_ST_RESET;
    end else begin
      status <= (status & ~(rd_stat ? prdata[1:0] : 2'h0)) |
                {ovf_evt, cap_irq};
    end
  end

  assign o_irq = |(status & mask);

  // wake pulse does not depend on the timer running
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= int_only & mask[icc_pkg::ICC_ST_CAP];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, latched in the setup phase

  logic [15:0] con_rd;

  always_comb begin
    con_rd = 16'h0000;
    con_rd[icc_pkg::ICC_CON_SIDL]      = stop_in_idle;
    con_rd[icc_pkg::ICC_CON_TSEL]      = timebase_select;
    con_rd[icc_pkg::ICC_CON_EVC +: 2]  = interrupt_event_count;
    con_rd[icc_pkg::ICC_CON_OV]        = locked;
    con_rd[icc_pkg::ICC_CON_BNE]       = ~empty;
    con_rd[icc_pkg::ICC_CON_MODE +: 3] = capture_mode_field;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      head_ok <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= ~hit;
      head_ok <= ~empty;
      unique case (i_apb.paddr)
        icc_pkg::ICC_ADDR_BUF:  prdata <= {16'h0000, head};
        icc_pkg::ICC_ADDR_CON:  prdata <= {16'h0000, con_rd};
        icc_pkg::ICC_ADDR_STAT: prdata <= {30'h0, status};
        icc_pkg::ICC_ADDR_MASK: prdata <= {30'h0, mask};
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign o_apb.prdata  = prdata;
  assign o_apb.pready  = 1'b1;
  assign o_apb.pslverr = pslverr & acc_ph;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  ovf_set_a: assert property (ovf_evt |=> locked && status[1])
    else $error("overflow not flagged");
  full_no_push_a: assert property (full |-> !push)
    else $error("push into full fifo");
  lock_hold_a: assert property (locked && !empty |=>
      count <= $past(count))
    else $error("capture stored while locked");
  bne_flag_a: assert property (push || (!empty && !pop)
      |=> con_rd[icc_pkg::ICC_CON_BNE])
    else $error("not-empty flag dropped early");
  pop_shift_a: assert property (pop && !push |=>
      count == $past(count) - 3'h1)
    else $error("read did not advance fifo");
  hall_no_ovf_a: assert property (is_hall && evt && full && !locked &&
      !status[1] |=> !locked && !status[1])
    else $error("overflow in both-edges mode");
  hall_irq_a: assert property (is_hall && evt |=> status[0])
    else $error("both-edges event did not flag");
  presc_clear_a: assert property (mode_off |=> presc == 4'h0)
    else $error("prescaler not cleared");
  wake_a: assert property (i_sleep && is_int && rise && mask[0]
      |=> o_wake)
    else $error("no wake on mode 111 edge");
  sleep_store_a: assert property (i_sleep |-> !push)
    else $error("capture stored in sleep");
  idle_int_a: assert property (i_idle && is_int |-> !push)
    else $error("capture stored in idle interrupt mode");
  stamp_src_a: assert property (push && !timebase_select && empty
      |=> head == $past(i_timer3_count))
    else $error("wrong timer sampled");
  irq_gate_a: assert property (!mask[0] && !mask[1] |-> !o_irq)
    else $error("interrupt not gated by enable");
  evcnt_once_a: assert property (evt && !is_hall && !int_only &&
      interrupt_event_count == 2'h3 && ev_cnt == 2'h0
      |-> !cap_irq)
    else $error("interrupt before event count reached");

  ovf_c:  cover property (ovf_evt);
  hall_c: cover property (is_hall && evt && full);
  wake_c: cover property (o_wake);
  pre_c:  cover property (push && capture_mode_field == icc_pkg::ICC_PRE16);

endmodule

// ==== sim/icc_pin_src.sv ====
// icc_pin_src: behavioural source of edges on the capture pin
// assumes the bench calls drive() from one process at a time
`timescale 1ns/1ps
module icc_pin_src (
  input  wire logic i_clock,
  output logic      o_pin
);
  // pin idles low until the first edge is asked for
  initial o_pin = 1'b0;

  //////////////////////////////////////////////////////////////////////
  // change the level after an edge, then hold it; a short hold is the
  // prompt case, a long one the slow case, never under two cycles
  task automatic drive(input logic lvl, input int hold);
    @(posedge i_clock);
    o_pin <= lvl;
    repeat ((hold < 2) ? 2 : hold) @(posedge i_clock);
  endtask
endmodule

// ==== sim/tb_top.sv ====
// tb_top: self-checking bench of the input capture channel
// assumes zero-wait apb and a pin source that holds levels >= 2 cycles
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic                  i_clock, i_rst_b, pin, irq, wake, wake_seen;
  logic                  t2on, t3on, slp, idl, last_err;
  logic [15:0]           t2, t3;
  int                    error_cnt, n_compared, cyc, hold;
  icc_pkg::icc_apb_req_t req;
  icc_pkg::icc_apb_rsp_t rsp;
  localparam logic [11:0] A_BUF  = icc_pkg::ICC_ADDR_BUF;
  localparam logic [11:0] A_CON  = icc_pkg::ICC_ADDR_CON;
  localparam logic [11:0] A_STAT = icc_pkg::ICC_ADDR_STAT;
  localparam logic [11:0] A_MASK = icc_pkg::ICC_ADDR_MASK;

  icc_capture_channel uut (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_apb(req), .o_apb(rsp), .i_capture_input_pin(pin),
    .i_timer2_count(t2), .i_timer3_count(t3), .i_timer2_on(t2on),
    .i_timer3_on(t3on), .i_sleep(slp), .i_idle(idl), .o_irq(irq),
    .o_wake(wake));
  icc_pin_src src (.i_clock(i_clock), .o_pin(pin));

  //////////////////////////////////////////////////////////////////////
  // clock, timeout and a sticky copy of the one-cycle wake pulse
  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  always @(posedge i_clock) if (wake === 1'b1) wake_seen <= 1'b1;

  //////////////////////////////////////////////////////////////////////
  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clock);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge i_clock);
    req.penable <= 1'b1;
    @(posedge i_clock);
    while (rsp.pready !== 1'b1) @(posedge i_clock);
    r = rsp.prdata;
    last_err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask
  // timer counts held well before the edge so the stamp is unambiguous
  task automatic pulse(input logic lvl, input logic [15:0] t);
    @(posedge i_clock);
    t3 <= t;
    t2 <= ~t;
    src.drive(lvl, hold);
  endtask
  task automatic rise(input logic [15:0] t);
    pulse(1'b1, t);
    pulse(1'b0, t);
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios; fifo reads never exceed what was stored
  task automatic s_reset;
    rchk(A_CON, 32'h0);
    rchk(A_STAT, 32'h0);
    rchk(A_MASK, 32'h0);
    `CHK(irq, 1'b0)
  endtask
  task automatic s_fifo;
    wr(A_CON, 32'h3);
    for (int i = 0; i < 5; i++) rise(16'h1000 + i);
    rchk(A_CON, 32'h1b);
    rchk(A_STAT, 32'h3);
    for (int i = 0; i < 3; i++) rchk(A_BUF, 32'h1000 + i);
    rise(16'h1999);
    rchk(A_BUF, 32'h1003);
    rchk(A_CON, 32'h3);
    rise(16'h1234);
    rchk(A_BUF, 32'h1234);
  endtask
  task automatic s_fall;
    wr(A_CON, 32'h82);
    rise(16'h0bbb);
    rchk(A_BUF, 32'hf444);
    rchk(A_CON, 32'h82);
    wr(A_CON, 32'h6);
    rise(16'h0ccc);
    rchk(A_CON, 32'h6);
  endtask
  task automatic s_pre;
    wr(A_CON, 32'h4);
    rise(16'h4001);
    rise(16'h4002);
    wr(A_CON, 32'h0);
    for (int m = 4; m < 6; m++) begin
      wr(A_CON, 32'(m));
      for (int i = 1; i < ((m == 4) ? 4 : 16); i++) rise(16'h4100 + i);
      rchk(A_CON, 32'(m));
      rise(16'h4fff);
      rchk(A_CON, 32'h8 | 32'(m));
      rchk(A_BUF, 32'h4fff);
    end
  endtask
  task automatic s_hall;
    logic [31:0] r;
    apb(1'b0, A_STAT, 32'h0, r);
    wr(A_MASK, 32'h0);
    wr(A_CON, 32'h61);
    hold = 2;
    rise(16'h5000);
    repeat (6) @(posedge i_clock);
    rchk(A_STAT, 32'h1);
    for (int i = 0; i < 3; i++) rise(16'h5001 + 16'(i));
    repeat (6) @(posedge i_clock);
    hold = 6;
    rchk(A_CON, 32'h69);
    `CHK(irq, 1'b0)
    rchk(A_STAT, 32'h1);
    for (int i = 0; i < 4; i++) rchk(A_BUF, 32'h5000 + 32'(i / 2));
  endtask
  task automatic s_evcnt;
    logic [31:0] r;
    wr(A_MASK, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(A_CON, 32'h0);
      wr(A_CON, (32'(k) << 5) | 32'h3);
      apb(1'b0, A_STAT, 32'h0, r);
      for (int i = 0; i < k; i++) rise(16'h6000);
      rchk(A_STAT, 32'h0);
      rise(16'h6000);
      @(negedge i_clock);
      `CHK(irq, 1'b1)
      rchk(A_STAT, 32'h1);
      @(negedge i_clock);
      `CHK(irq, 1'b0)
      for (int i = 0; i <= k; i++) rchk(A_BUF, 32'h6000);
    end
  endtask
  task automatic s_sleep;
    wr(A_CON, 32'h7);
    t2on <= 1'b0;
    t3on <= 1'b0;
    slp <= 1'b1;
    wake_seen <= 1'b0;
    rise(16'h7000);
    `CHK(wake_seen, 1'b1)
    rchk(A_STAT, 32'h1);
    rchk(A_CON, 32'h7);
    slp <= 1'b0;
    idl <= 1'b1;
    t3on <= 1'b1;
    wr(A_CON, 32'h3);
    rise(16'h7100);
    rchk(A_CON, 32'hb);
    rchk(A_BUF, 32'h7100);
    wr(A_CON, 32'h2003);
    rise(16'h7200);
    rchk(A_CON, 32'h2003);
    wr(A_CON, 32'h7);
    wake_seen <= 1'b0;
    rise(16'h7300);
    `CHK(wake_seen, 1'b1)
    rchk(A_CON, 32'h7);
    idl <= 1'b0;
  endtask
  // unmapped place: error flagged and nothing read back
  task automatic s_unmapped;
    logic [31:0] r;
    apb(1'b0, 12'h004, 32'h0, r);
    `CHK(r, 32'h0)
    `CHK(last_err, 1'b1)
  endtask

  //////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    i_clock = 1'b0;
    i_rst_b = 1'b0;
    req = '0;
    t2 = 16'h0000;
    t3 = 16'h0000;
    t2on = 1'b1;
    t3on = 1'b1;
    slp = 1'b0;
    idl = 1'b0;
    wake_seen = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    hold = 6;
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    s_reset();
    s_fifo();
    s_fall();
    s_pre();
    s_hall();
    s_evcnt();
    s_sleep();
    s_unmapped();
    tally_and_finish();
  end
endmodule
